// ### design/nose_top.sv
`timescale 1ns/1ps
// Behaviour
// - secure region holds thirty good pages of 2112 bytes each.
// - with secure region enabled, 02h/10h program and 13h reads it.
// - with bits 6 and 7 set, secure region is read-only.
// - protect/enable decode: normal, secure access, undefined, lock on 10h.
// - status bit 0 is high while any operation runs.
// - status bit 1 is write latch; gates program/erase; 04h clears it.
// - program failure bit set on failure or protected target, cleared at execute.
// - status bits 5:4 code correction outcome: none, fixed, unfixed.
// - correction bits clear at read start, update at read completion.
// - after reset, device loads page 0 block 0 and reports its outcome.
// - correction bits carry no status while correction is disabled.
// - correction is active after power-up.
// - config bit 4 enables correction; device follows it.
// - program computes check bits and stores them in spare area.
// - read checks, corrects up to four bits, outputs corrected data.
// - four 512B main segments, then four 16B spare segments to 83Fh.
module nose_top #(
    parameter int SEGS = 4
) (
    // core clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // link side, on the link clock
    input wire logic LINK_CLK,
    input wire logic LINK_CMD_VALID,
    input wire nose_pkg::nose_cmd_type LINK_CMD,
    output logic LINK_RVALID,
    output logic [7:0] LINK_RDATA,
    // array side, on the core clock
    output logic ARR_REQ,
    output nose_pkg::nose_arr_op_type ARR_OP,
    output logic [16:0] ARR_PAGE,
    output logic ARR_OTP,
    output logic ARR_ECC_ON,
    input wire logic ARR_DONE,
    input wire logic ARR_FAIL,
    input wire logic [SEGS*nose_pkg::ERR_W-1:0] ARR_SEG_ERRS,
    // visible register state
    output nose_pkg::nose_status_type STATUS,
    output logic [7:0] CONFIG
);
    import nose_pkg::*;

    typedef enum logic [1:0] {
        S_BOOT,
        S_IDLE,
        S_WAIT,
        S_RESET
    } nose_state_type;

    // link domain state
    nose_cmd_type lcmd_q, lcmd_d;
    logic lreq_q, lreq_d;
    logic lack_s1_q, lack_s2_q, lack_s3_q;
    logic lrvalid_q, lrvalid_d;
    logic [7:0] lrdata_q, lrdata_d;

    // core domain state
    logic creq_s1_q, creq_s2_q, creq_s3_q;
    nose_state_type state_q, state_d;
    logic [7:0] cfg_q, cfg_d;
    logic wel_q, wel_d;
    logic pfail_q, pfail_d;
    logic efail_q, efail_d;
    logic [1:0] eccst_q, eccst_d;
    logic lock_q, lock_d;
    logic ack_q, ack_d;
    logic [7:0] ans_q, ans_d;
    logic areq_q, areq_d;
    nose_arr_op_type aop_q, aop_d;
    logic [16:0] apage_q, apage_d;
    logic aotp_q, aotp_d;
    logic [3:0] cnt_q, cnt_d;
    nose_status_type stat_q, stat_d;

    logic cmd_new;
    logic [1:0] ecc_res;
    logic ecc_on;
    logic otp_en;
    logic otp_prot;
    logic [16:0] cmd_page;
    logic otp_page_ok;

    // link side: take a command, raise a request toggle, catch the answer
    always_comb begin
        lcmd_d = lcmd_q;
        lreq_d = lreq_q;
        lrvalid_d = 1'b0;
        lrdata_d = lrdata_q;
        if (LINK_CMD_VALID) begin
            lcmd_d = LINK_CMD;
            lreq_d = !lreq_q;
        end
        if (lack_s2_q != lack_s3_q) begin
            lrvalid_d = 1'b1;
            lrdata_d = ans_q; // stable until the next command
        end
    end

    // link side registers
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            lcmd_q <= '0;
            lreq_q <= 1'b0;
            lack_s1_q <= 1'b0;
            lack_s2_q <= 1'b0;
            lack_s3_q <= 1'b0;
            lrvalid_q <= 1'b0;
            lrdata_q <= 8'h00;
        end else begin
            lcmd_q <= lcmd_d;
            lreq_q <= lreq_d;
            lack_s1_q <= ack_q;
            lack_s2_q <= lack_s1_q;
            lack_s3_q <= lack_s2_q;
            lrvalid_q <= lrvalid_d;
            lrdata_q <= lrdata_d;
        end
    end

    assign cmd_new = creq_s2_q != creq_s3_q;
    assign ecc_on = cfg_q[CFG_ECC_BIT];
    assign otp_en = cfg_q[CFG_ENABLE_BIT];
    assign otp_prot = cfg_q[CFG_PROTECT_BIT];
    assign cmd_page = lcmd_q.addr[16:0];
    assign otp_page_ok = (cmd_page >= OTP_FIRST_PAGE) &&
        (cmd_page <= OTP_LAST_PAGE);

    // correction outcome of the current array read
    nose_ecc #(
        .SEGS(SEGS),
        .EW(ERR_W)
    ) u_ecc (
        .enable(ecc_on),
        .seg_errs(ARR_SEG_ERRS),
        .result(ecc_res)
    );

    // command decode, operation sequencing and status bits
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        wel_d = wel_q;
        pfail_d = pfail_q;
        efail_d = efail_q;
        eccst_d = eccst_q;
        lock_d = lock_q;
        ack_d = ack_q;
        ans_d = ans_q;
        areq_d = 1'b0;
        aop_d = aop_q;
        apage_d = apage_q;
        aotp_d = aotp_q;
        cnt_d = cnt_q;
        case (state_q)
            S_BOOT: begin
                // automatic load of page 0 of block 0
                areq_d = 1'b1;
                aop_d = ARR_READ;
                apage_d = BOOT_PAGE;
                aotp_d = 1'b0;
                eccst_d = ECC_CLEAN;
                state_d = S_WAIT;
            end
            S_WAIT: begin
                if (ARR_DONE) begin
                    state_d = S_IDLE;
                    if (aop_q == ARR_READ) begin
                        eccst_d = ecc_res;
                    end else if (aop_q == ARR_PROGRAM) begin
                        pfail_d = pfail_q | ARR_FAIL;
                        wel_d = 1'b0;
                    end else begin
                        efail_d = efail_q | ARR_FAIL;
                        wel_d = 1'b0;
                    end
                end
            end
            S_RESET: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                if (cmd_new) begin
                    if (lcmd_q.opcode == OP_WR_ENABLE) begin
                        wel_d = 1'b1;
                    end else if (lcmd_q.opcode == OP_WR_DISABLE) begin
                        wel_d = 1'b0;
                    end else if (lcmd_q.opcode == OP_SET_FEATURE) begin
                        if (lcmd_q.addr[7:0] == FEAT_CONFIG) begin
                            cfg_d = (cfg_q & ~CFG_WR_MASK) |
                                (lcmd_q.data & CFG_WR_MASK);
                        end
                    end else if (lcmd_q.opcode == OP_PAGE_READ) begin
                        eccst_d = ECC_CLEAN;
                        areq_d = 1'b1;
                        aop_d = ARR_READ;
                        apage_d = cmd_page;
                        aotp_d = otp_en;
                        state_d = S_WAIT;
                    end else if (lcmd_q.opcode == OP_PROG_EXEC &&
                        wel_q) begin
                        pfail_d = 1'b0;
                        if (otp_en && otp_prot) begin
                            lock_d = 1'b1;
                            wel_d = 1'b0;
                        end else if (otp_en &&
                            (lock_q || !otp_page_ok)) begin
                            pfail_d = 1'b1;
                            wel_d = 1'b0;
                        end else begin
                            // array computes and stores check bits
                            areq_d = 1'b1;
                            aop_d = ARR_PROGRAM;
                            apage_d = cmd_page;
                            aotp_d = otp_en;
                            state_d = S_WAIT;
                        end
                    end else if (lcmd_q.opcode == OP_BLOCK_ERASE &&
                        wel_q) begin
                        efail_d = 1'b0;
                        if (otp_en) begin
                            efail_d = 1'b1;
                            wel_d = 1'b0;
                        end else begin
                            areq_d = 1'b1;
                            aop_d = ARR_ERASE;
                            apage_d = cmd_page;
                            aotp_d = 1'b0;
                            state_d = S_WAIT;
                        end
                    end else if (lcmd_q.opcode == OP_RESET) begin
                        pfail_d = 1'b0;
                        efail_d = 1'b0;
                        eccst_d = ECC_CLEAN;
                        wel_d = 1'b0;
                        cnt_d = 4'(RESET_CMD_CYCLES);
                        state_d = S_RESET;
                    end
                end
            end
        endcase
        // every command is answered; get-feature carries data
        if (cmd_new) begin
            ack_d = !ack_q;
            ans_d = 8'h00;
            if (lcmd_q.opcode == OP_GET_FEATURE) begin
                if (lcmd_q.addr[7:0] == FEAT_CONFIG) begin
                    ans_d = cfg_q;
                end else if (lcmd_q.addr[7:0] == FEAT_STATUS) begin
                    ans_d = stat_q;
                end
            end
        end
    end

    // status byte built from the next values
    always_comb begin
        stat_d = '0;
        stat_d.operation_running = state_d != S_IDLE;
        stat_d.write_permission_latch = wel_d;
        stat_d.erase_failed_flag = efail_d;
        stat_d.program_failed_flag = pfail_d;
        stat_d.correction_result_hi = eccst_d[1];
        stat_d.correction_result_lo = eccst_d[0];
    end

    // core registers
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            creq_s1_q <= 1'b0;
            creq_s2_q <= 1'b0;
            creq_s3_q <= 1'b0;
            state_q <= S_BOOT;
            cfg_q <= CFG_RESET;
            wel_q <= 1'b0;
            pfail_q <= 1'b0;
            efail_q <= 1'b0;
            eccst_q <= ECC_CLEAN;
            lock_q <= 1'b0;
            ack_q <= 1'b0;
            ans_q <= 8'h00;
            areq_q <= 1'b0;
            aop_q <= ARR_READ;
            apage_q <= '0;
            aotp_q <= 1'b0;
            cnt_q <= 4'h0;
            stat_q <= 8'h01;
        end else begin
            creq_s1_q <= lreq_q;
            creq_s2_q <= creq_s1_q;
            creq_s3_q <= creq_s2_q;
            state_q <= state_d;
            cfg_q <= cfg_d;
            wel_q <= wel_d;
            pfail_q <= pfail_d;
            efail_q <= efail_d;
            eccst_q <= eccst_d;
            lock_q <= lock_d;
            ack_q <= ack_d;
            ans_q <= ans_d;
            areq_q <= areq_d;
            aop_q <= aop_d;
            apage_q <= apage_d;
            aotp_q <= aotp_d;
            cnt_q <= cnt_d;
            stat_q <= stat_d;
        end
    end

    // outputs straight from flops
    assign LINK_RVALID = lrvalid_q;
    assign LINK_RDATA = lrdata_q;
    assign ARR_REQ = areq_q;
    assign ARR_OP = aop_q;
    assign ARR_PAGE = apage_q;
    assign ARR_OTP = aotp_q;
    assign ARR_ECC_ON = cfg_q[CFG_ECC_BIT];
    assign STATUS = stat_q;
    assign CONFIG = cfg_q;
endmodule : nose_top

// ### inc/nose_pkg.sv
package nose_pkg;
    // command opcodes seen on the link
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_SET_FEATURE = 8'h1F;
    localparam logic [7:0] OP_GET_FEATURE = 8'h0F;
    localparam logic [7:0] OP_PAGE_READ = 8'h13;
    localparam logic [7:0] OP_PROG_LOAD = 8'h02;
    localparam logic [7:0] OP_PROG_EXEC = 8'h10;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_RESET = 8'hFF;
    // feature locations
    localparam logic [7:0] FEAT_CONFIG = 8'hB0;
    localparam logic [7:0] FEAT_STATUS = 8'hC0;
    // secure_area_config fields and reset value
    localparam int CFG_PROTECT_BIT = 7;
    localparam int CFG_ENABLE_BIT = 6;
    localparam int CFG_ECC_BIT = 4;
    localparam logic [7:0] CFG_WR_MASK = 8'hD1;
    localparam logic [7:0] CFG_RESET = 8'h10;
    // operation_status field positions
    localparam int ST_RUN_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_EFAIL_BIT = 2;
    localparam int ST_PFAIL_BIT = 3;
    localparam int ST_ECC_LO_BIT = 4;
    localparam int ST_ECC_HI_BIT = 5;
    // correction result codes
    localparam logic [1:0] ECC_CLEAN = 2'h0;
    localparam logic [1:0] ECC_FIXED = 2'h1;
    localparam logic [1:0] ECC_FAILED = 2'h2;
    localparam int ECC_MAX_FIX = 4;
    // secure region geometry
    localparam int OTP_PAGES = 30;
    localparam int PAGE_BYTES = 2112;
    localparam logic [16:0] OTP_FIRST_PAGE = 17'h00002;
    localparam logic [16:0] OTP_LAST_PAGE = 17'h0001F;
    localparam logic [16:0] BOOT_PAGE = 17'h00000;
    // page segment layout
    localparam int SEGMENTS = 4;
    localparam logic [11:0] MAIN_BASE = 12'h000;
    localparam logic [11:0] MAIN_SEG_BYTES = 12'h200;
    localparam logic [11:0] SPARE_BASE = 12'h800;
    localparam logic [11:0] SPARE_LAST = 12'h83F;
    localparam logic [11:0] SPARE_SEG_BYTES = 12'h010;
    localparam logic [11:0] META1_OFS = 12'h004;
    localparam logic [11:0] META1_BYTES = 12'h004;
    localparam logic [11:0] RSVD2_OFS = 12'h008;
    // busy cycles of the reset command
    localparam int RESET_CMD_CYCLES = 8;
    localparam int ERR_W = 4;

    typedef enum logic [1:0] {
        ARR_READ,
        ARR_PROGRAM,
        ARR_ERASE
    } nose_arr_op_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] data;
    } nose_cmd_type;

    typedef struct packed {
        logic [1:0] reserved;
        logic correction_result_hi;
        logic correction_result_lo;
        logic program_failed_flag;
        logic erase_failed_flag;
        logic write_permission_latch;
        logic operation_running;
    } nose_status_type;
endpackage : nose_pkg

// ### design/nose_ecc.sv
`timescale 1ns/1ps
module nose_ecc #(
    parameter int SEGS = 4,
    parameter int EW = 4
) (
    // setting
    input wire logic enable,
    // per-segment bit error counts from the array read
    input wire logic [SEGS*EW-1:0] seg_errs,
    // outcome
    output logic [1:0] result
);
    import nose_pkg::*;

    logic [SEGS-1:0] seg_fixed;
    logic [SEGS-1:0] seg_bad;

    // classify each segment: main part plus first_metadata_field
    genvar g;
    generate
        for (g = 0; g < SEGS; g++) begin : g_seg
            logic [EW-1:0] n;
            assign n = seg_errs[g*EW +: EW];
            assign seg_bad[g] = n > EW'(ECC_MAX_FIX);
            assign seg_fixed[g] = (n != '0) && !seg_bad[g];
        end
    endgenerate

    // worst segment wins; a disabled engine reports nothing
    always_comb begin
        if (!enable) begin
            result = ECC_CLEAN;
        end else if (|seg_bad) begin
            result = ECC_FAILED;
        end else if (|seg_fixed) begin
            result = ECC_FIXED;
        end else begin
            result = ECC_CLEAN;
        end
    end
endmodule : nose_ecc

// ### sim/nose_chk.sv
`timescale 1ns/1ps
module nose_chk #(
    parameter int SEGS = 4
) (
    // core clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // array side
    input wire logic ARR_REQ,
    input wire nose_pkg::nose_arr_op_type ARR_OP,
    input wire logic ARR_OTP,
    input wire logic ARR_ECC_ON,
    input wire logic ARR_DONE,
    input wire logic ARR_FAIL,
    input wire logic [SEGS*nose_pkg::ERR_W-1:0] ARR_SEG_ERRS,
    // register state
    input wire nose_pkg::nose_status_type STATUS,
    input wire logic [7:0] CONFIG
);
    import nose_pkg::*;
    logic wait_q;
    logic wait_d;
    logic fin;
    logic [1:0] res;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // worst segment decides the grade
    function automatic logic [1:0] grade(input logic [SEGS*ERR_W-1:0] e);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < SEGS; i++) begin
            if (e[i*ERR_W +: ERR_W] > m)
                m = e[i*ERR_W +: ERR_W];
        end
        if (m == 4'h0)
            return ECC_CLEAN;
        return (m > ECC_MAX_FIX) ? ECC_FAILED : ECC_FIXED;
    endfunction : grade
    // array op outstanding between request and done
    always_comb wait_d = ARR_REQ | (wait_q & ~ARR_DONE);
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST)
            wait_q <= 1'b0;
        else
            wait_q <= wait_d;
    end
    // completion and correction field
    assign fin = wait_q && ARR_DONE;
    assign res = {STATUS.correction_result_hi, STATUS.correction_result_lo};
    run_on_a:
        assert property (ARR_REQ |=> STATUS.operation_running [*2])
        else $error("busy flag not raised");
    run_off_a:
        assert property (fin |=> !STATUS.operation_running)
        else $error("busy flag not dropped");
    latch_gate_a:
        assert property (ARR_REQ && ARR_OP != ARR_READ
            |-> STATUS.write_permission_latch)
        else $error("write op without latch");
    res_clear_a:
        assert property (ARR_REQ && ARR_OP == ARR_READ |=> res == ECC_CLEAN)
        else $error("result not cleared at read start");
    res_grade_a:
        assert property (fin && ARR_OP == ARR_READ && ARR_ECC_ON
            |=> res == grade($past(ARR_SEG_ERRS)))
        else $error("wrong correction grade");
    res_off_a:
        assert property (fin && ARR_OP == ARR_READ && !ARR_ECC_ON
            |=> res == ECC_CLEAN)
        else $error("result set with correction off");
    ecc_cfg_a:
        assert property (wait_q |-> $stable(ARR_ECC_ON) &&
            ARR_ECC_ON == CONFIG[CFG_ECC_BIT])
        else $error("correction steer changed during operation");
    pfail_set_a:
        assert property (fin && ARR_OP == ARR_PROGRAM
            |=> STATUS.program_failed_flag == $past(ARR_FAIL))
        else $error("program fail flag wrong");
    efail_set_a:
        assert property (fin && ARR_OP == ARR_ERASE
            |=> STATUS.erase_failed_flag == $past(ARR_FAIL))
        else $error("erase fail flag wrong");
    otp_sel_a:
        assert property (ARR_REQ |-> ARR_OTP == CONFIG[CFG_ENABLE_BIT])
        else $error("secure select wrong");
    lock_prog_a:
        assert property (ARR_REQ && ARR_OP == ARR_PROGRAM
            |-> !(CONFIG[CFG_PROTECT_BIT] && CONFIG[CFG_ENABLE_BIT]))
        else $error("program while locking");
    // main scenarios
    cover property (fin && ARR_OP == ARR_READ && !ARR_ECC_ON);
    cover property (fin && ARR_OP == ARR_PROGRAM && ARR_FAIL);
    cover property (ARR_REQ && ARR_OTP);
endmodule : nose_chk

bind nose_top nose_chk #(.SEGS(SEGS)) i_nose_chk (
    .CLOCK(CLOCK), .RST(RST), .ARR_REQ(ARR_REQ), .ARR_OP(ARR_OP),
    .ARR_OTP(ARR_OTP), .ARR_ECC_ON(ARR_ECC_ON), .ARR_DONE(ARR_DONE),
    .ARR_FAIL(ARR_FAIL), .ARR_SEG_ERRS(ARR_SEG_ERRS),
    .STATUS(STATUS), .CONFIG(CONFIG)
);

// ### sim/nose_host.sv
`timescale 1ns/1ps
module nose_host (
    // link clock
    input wire logic link_clk,
    // command out
    output logic cmd_valid,
    output nose_pkg::nose_cmd_type cmd,
    // answer in
    input wire logic rvalid,
    input wire logic [7:0] rdata
);
    import nose_pkg::*;
    // idle link lines
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // one pulse, then wait for the answer; released lines flip
    task automatic send(input nose_cmd_type c, output logic [7:0] q,
            output logic ok);
        ok = 1'b0;
        q = ~c.data;
        @(negedge link_clk);
        cmd_valid = 1'b1;
        cmd = c;
        @(negedge link_clk);
        cmd_valid = 1'b0;
        cmd = ~c;
        for (int i = 0; i < 64 && ok == 1'b0; i++) begin
            @(negedge link_clk);
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                q = rdata;
            end
        end
    endtask : send
endmodule : nose_host

// ### sim/test_nose_top.sv
`timescale 1ns/1ps
module test_nose_top;
    import nose_pkg::*;
    // clocks, reset and array answers
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic arr_done = 1'b0;
    logic arr_fail = 1'b0;
    logic [15:0] arr_seg_errs = 16'h0000;
    // design outputs and link wires
    logic cmd_valid;
    nose_cmd_type cmd;
    logic rvalid;
    logic [7:0] rdata;
    logic arr_req;
    nose_arr_op_type arr_op;
    logic [16:0] arr_page;
    logic arr_otp;
    logic arr_ecc_on;
    nose_status_type status;
    logic [7:0] config_v;
    // bench state
    logic fail_v = 1'b0;
    logic [15:0] errs_v = 16'h0030;
    logic [19:0] last_req = 20'h00000;
    logic [19:0] exp_rec = 20'h00000;
    logic [7:0] rdata_q;
    int req_cnt = 0;
    int exp_n = 0;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    nose_top i_nose_top (
        .CLOCK(clock), .RST(rst), .LINK_CLK(link_clk),
        .LINK_CMD_VALID(cmd_valid), .LINK_CMD(cmd),
        .LINK_RVALID(rvalid), .LINK_RDATA(rdata),
        .ARR_REQ(arr_req), .ARR_OP(arr_op), .ARR_PAGE(arr_page),
        .ARR_OTP(arr_otp), .ARR_ECC_ON(arr_ecc_on), .ARR_DONE(arr_done),
        .ARR_FAIL(arr_fail), .ARR_SEG_ERRS(arr_seg_errs),
        .STATUS(status), .CONFIG(config_v)
    );
    nose_host i_nose_host (
        .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .rvalid(rvalid), .rdata(rdata)
    );
    // core and link clocks, unrelated phase
    initial begin
        forever #2.5 clock = ~clock;
    end
    initial begin
        #1.7;
        forever #6 link_clk = ~link_clk;
    end
    // cycle ceiling
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    // array model: record request, answer after a delay, then scramble
    always @(negedge clock) begin
        if (arr_req === 1'b1) begin
            req_cnt++;
            last_req = {arr_op, arr_otp, arr_page};
            repeat (30) @(negedge clock);
            arr_done <= 1'b1;
            arr_fail <= fail_v;
            arr_seg_errs <= errs_v;
            @(negedge clock);
            arr_done <= 1'b0;
            arr_fail <= ~fail_v;
            arr_seg_errs <= ~errs_v;
        end
    end
    // byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    // request count and last request compare
    task automatic chk_req(input logic [27:0] exp);
        compares++;
        if ({req_cnt[7:0], last_req} !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time,
                {req_cnt[7:0], last_req}, exp);
        end
    endtask : chk_req
    // link command helpers
    task automatic cmd_do(input logic [7:0] op, input logic [23:0] a,
            input logic [7:0] d);
        logic ok;
        i_nose_host.send('{op, a, d}, rdata_q, ok);
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t no answer %h %h", $time, op, a);
        end
    endtask : cmd_do
    task automatic st(input logic [7:0] exp);
        cmd_do(OP_GET_FEATURE, {16'h0000, FEAT_STATUS}, 8'h00);
        chk8(rdata_q, exp);
    endtask : st
    task automatic cfg(input logic [7:0] v);
        cmd_do(OP_SET_FEATURE, {16'h0000, FEAT_CONFIG}, v);
        chk8(config_v, v);
        cmd_do(OP_GET_FEATURE, {16'h0000, FEAT_CONFIG}, 8'h00);
        chk8(rdata_q, v);
    endtask : cfg
    task automatic wren();
        cmd_do(OP_WR_ENABLE, 24'h000000, 8'h00);
    endtask : wren
    task automatic idle();
        for (int i = 0; i < 100; i++) begin
            @(negedge clock);
            if (status.operation_running === 1'b0)
                break;
        end
    endtask : idle
    task automatic acc(input logic [19:0] rec);
        exp_n++;
        exp_rec = rec;
    endtask : acc
    // boot read of page 0 and its grade
    task automatic t_boot();
        idle();
        acc({ARR_READ, 1'b0, BOOT_PAGE});
        chk_req({exp_n[7:0], exp_rec});
        chk8(status, 8'h10);
    endtask : t_boot
    // reads at grade boundaries, busy poll mid-read
    task automatic t_read();
        logic [15:0] pat [3] = '{16'h0000, 16'h4040, 16'h0502};
        logic [7:0] ex [3] = '{8'h00, 8'h10, 8'h20};
        for (int i = 0; i < 3; i++) begin
            errs_v = pat[i];
            cmd_do(OP_PAGE_READ, 24'h000040 + 24'(i), 8'h00);
            st(8'h01);
            idle();
            acc({ARR_READ, 1'b0, 17'h00040 + 17'(i)});
            chk_req({exp_n[7:0], exp_rec});
            st(ex[i]);
        end
    endtask : t_read
    // correction switched off
    task automatic t_ecc_off();
        cfg(8'h00);
        errs_v = 16'h0005;
        cmd_do(OP_PAGE_READ, 24'h000050, 8'h00);
        idle();
        chk8({7'h00, arr_ecc_on}, 8'h00);
        st(8'h00);
        cfg(CFG_RESET);
        acc({ARR_READ, 1'b0, 17'h00050});
    endtask : t_ecc_off
    // latch gating, fail flags set and cleared
    task automatic t_prog();
        logic [7:0] op [4] = '{OP_PROG_EXEC, OP_PROG_EXEC,
            OP_BLOCK_ERASE, OP_BLOCK_ERASE};
        nose_arr_op_type kd [4] = '{ARR_PROGRAM, ARR_PROGRAM,
            ARR_ERASE, ARR_ERASE};
        logic [7:0] ex [4] = '{8'h08, 8'h00, 8'h04, 8'h00};
        fail_v = 1'b1;
        cmd_do(OP_PROG_EXEC, 24'h000100, 8'h00);
        st(8'h00);
        chk_req({exp_n[7:0], exp_rec});
        wren();
        st(8'h02);
        cmd_do(OP_WR_DISABLE, 24'h000000, 8'h00);
        st(8'h00);
        for (int i = 0; i < 4; i++) begin
            fail_v = ~i[0];
            wren();
            cmd_do(op[i], 24'h000100, 8'h00);
            idle();
            acc({kd[i], 1'b0, 17'h00100});
            chk_req({exp_n[7:0], exp_rec});
            st(ex[i]);
        end
    endtask : t_prog
    // secure region: range, read, lock, refusals, reset command
    task automatic t_otp();
        logic [16:0] pg [4] = '{17'h00002, 17'h0001F, 17'h00020, 17'h00001};
        logic [7:0] ex [4] = '{8'h00, 8'h00, 8'h08, 8'h08};
        fail_v = 1'b0;
        errs_v = 16'h0000;
        cfg(8'h50);
        for (int i = 0; i < 4; i++) begin
            wren();
            cmd_do(OP_PROG_EXEC, {7'h00, pg[i]}, 8'h00);
            idle();
            if (ex[i] == 8'h00)
                acc({ARR_PROGRAM, 1'b1, pg[i]});
            chk_req({exp_n[7:0], exp_rec});
            st(ex[i]);
        end
        cmd_do(OP_PAGE_READ, 24'h000003, 8'h00);
        idle();
        acc({ARR_READ, 1'b1, 17'h00003});
        chk_req({exp_n[7:0], exp_rec});
        cfg(8'hD0);
        wren();
        cmd_do(OP_PROG_EXEC, 24'h000004, 8'h00);
        st(8'h00);
        cmd_do(OP_PAGE_READ, 24'h000005, 8'h00);
        idle();
        acc({ARR_READ, 1'b1, 17'h00005});
        chk_req({exp_n[7:0], exp_rec});
        cfg(8'h50);
        wren();
        cmd_do(OP_PROG_EXEC, 24'h000004, 8'h00);
        st(8'h08);
        wren();
        cmd_do(OP_BLOCK_ERASE, 24'h000040, 8'h00);
        st(8'h0C);
        chk_req({exp_n[7:0], exp_rec});
        cmd_do(OP_RESET, 24'h000000, 8'h00);
        idle();
        st(8'h00);
        chk8(config_v, 8'h50);
        cfg(CFG_RESET);
    endtask : t_otp
    // verdict
    task automatic end_sim();
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        repeat (8) @(negedge clock);
        chk8(status, 8'h01);
        chk8(config_v, CFG_RESET);
        rst = 1'b0;
        t_boot();
        t_read();
        t_ecc_off();
        t_prog();
        t_otp();
        end_sim();
    end
endmodule : test_nose_top
